//--- shared/dmsa_consts.vh
// Constants of the data-memory and special-register access block
`ifndef DMSA_CONSTS_VH
`define DMSA_CONSTS_VH

// Core data-memory addresses of the special registers (bank independent)
`define DMSA_A_IND0 8'h00
`define DMSA_A_PTR0 8'h01
`define DMSA_A_IND1 8'h02
`define DMSA_A_PTR1 8'h03
`define DMSA_A_BANK 8'h04
`define DMSA_A_WORK 8'h05
`define DMSA_A_PCL 8'h06
`define DMSA_A_TBLP 8'h07
`define DMSA_A_TABLE_HIGH_BYTE_OUT 8'h08
`define DMSA_A_TABLE_ADDRESS_HIGH 8'h09
`define DMSA_A_STAT 8'h0a
`define DMSA_A_SYSTEM_CONTROL_REG 8'h0b
// First general-purpose location; 0c..3f are reserved and read zero
`define DMSA_GP_BASE 8'h40

// Avalon byte offsets of the control and status registers
`define DMSA_R_BANK 4'h0
`define DMSA_R_STAT 4'h1
`define DMSA_R_SYSTEM_CONTROL_REG 4'h2
`define DMSA_R_TABLE_ADDRESS_HIGH 4'h3
`define DMSA_R_TABLE_HIGH_BYTE_OUT 4'h4
`define DMSA_R_PCL 4'h5
`define DMSA_R_WORK 4'h6
`define DMSA_R_PTR0 4'h7
`define DMSA_R_PTR1 4'h8

// Field positions
`define DMSA_ST_WDT 5
`define DMSA_ST_SLP 4
`define DMSA_ST_OV 3
`define DMSA_ST_Z 2
`define DMSA_ST_AC 1
`define DMSA_ST_C 0
`define DMSA_SC_TBEN 6

// Reset values and masks
`define DMSA_BANK_RST 2'h0
`define DMSA_SYSTEM_CONTROL_REG_RST 8'h00
`define DMSA_SYSTEM_CONTROL_REG_MASK 8'hf1
`define DMSA_STAT_WMASK 8'h0f

// Timing: dummy cycle after a program-counter low-byte write
`define DMSA_PCL_DUMMY 1
// Bus answer latency in cycles (request taken on the second edge)
`define DMSA_BUS_WAIT 1

`endif

//--- tb/dmsa_core_asserts.sv
// Port checker of the data-memory access block
`include "dmsa_consts.vh"
module dmsa_chk (
  input logic clk_sys, // Clock
  input logic rst_n, // Reset, low
  input logic core_wr, // Core write
  input logic [7:0] core_addr, // Core address
  input logic wdt_timeout, // Watchdog event
  input logic watchdog_clear_instruction_exec, // Watchdog clear
  input logic halt_exec, // Sleep entry
  input logic pcl_jump, // Jump pulse
  input logic dummy_cycle, // Dummy pulse
  input logic halt_flag, // Sleep flag
  input logic wdt_flag, // Watchdog flag
  input logic [3:0] avs_address, // Bus address
  input logic avs_read, // Bus read
  input logic avs_write, // Bus write
  input logic [31:0] avs_readdata, // Bus data
  input logic avs_waitrequest // Bus wait
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire pcl_wr = core_wr && core_addr == `DMSA_A_PCL;
  wire calm = !(wdt_timeout || watchdog_clear_instruction_exec || halt_exec);
  a_bus_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("bus answer not after one wait state");
  a_bank_high_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address == `DMSA_R_BANK |-> avs_readdata[7:2] == 6'h00) else $error("bank bits high");
  a_pcl_dummy: assert property (pcl_wr |=> pcl_jump ##1 dummy_cycle)
    else $error("no jump or dummy cycle");
  a_wdt_set: assert property (wdt_timeout |=> wdt_flag)
    else $error("watchdog flag not set");
  a_sleep_set: assert property (halt_exec |=> halt_flag)
    else $error("sleep flag not set");
  a_clear_both: assert property (watchdog_clear_instruction_exec && !wdt_timeout && !halt_exec |=>
    !wdt_flag && !halt_flag) else $error("clear left a flag set");
  a_halt_watchdog_clear_instruction: assert property (halt_exec && !wdt_timeout |=> !wdt_flag)
    else $error("sleep entry kept watchdog flag");
  a_flags_hold: assert property (calm |=> $stable(wdt_flag) && $stable(halt_flag))
    else $error("system flag changed without event");
  c_pcl: cover property (pcl_wr);
  c_halt: cover property (halt_exec);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule // dmsa_chk
bind dmsa_core dmsa_chk u_chk (.*);

//--- tb/dmsa_core_model.sv
// Behavioural processor core issuing data-memory accesses
module dmsa_core_model (
  input logic clk_sys, // Clock
  output logic core_rd = 1'b0, // Read strobe
  output logic core_wr = 1'b0, // Write strobe
  output logic [7:0] core_addr = 8'h00, // Address
  output logic [7:0] core_wdata = 8'h00, // Write data
  input logic [7:0] core_rdata // Read data
);
  // Entered right after an edge; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core_addr <= a;
    core_wdata <= d;
    core_wr <= 1'b1;
    @(posedge clk_sys);
    core_wr <= 1'b0;
    core_addr <= ~a;
    core_wdata <= ~d;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    core_addr <= a;
    core_rd <= 1'b1;
    @(posedge clk_sys);
    core_rd <= 1'b0;
    core_addr <= ~a;
    @(negedge clk_sys);
    d = core_rdata;
    @(posedge clk_sys);
  endtask
endmodule // dmsa_core_model

//--- tb/tb_top.sv
// Self-checking bench of the data-memory access block
`include "dmsa_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic power_up = 1'b1;
  logic wdt_halt_rst = 1'b0;
  logic wdt_timeout = 1'b0;
  logic watchdog_clear_instruction_exec = 1'b0;
  logic halt_exec = 1'b0;
  logic alu_upd = 1'b0;
  logic tbl_done = 1'b0;
  logic [3:0] alu_flags = 4'h0;
  logic [3:0] pc_page = 4'h5;
  logic [15:0] tbl_word = 16'h0000;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic core_rd, core_wr, pcl_jump, dummy_cycle, halt_flag, wdt_flag, avs_waitrequest;
  logic [7:0] core_addr, core_wdata, core_rdata, pcl_value, d8;
  logic [11:0] tbl_addr;
  logic [31:0] avs_readdata, r;
  int mismatches = 0;
  int cmp_count = 0;
  // Rows: read flag, core address, write data or expected read data
  logic [16:0] rows [19] = '{17'h00402, 17'h00345, 17'h002a5, 17'h0453c, 17'h102a5,
    17'h1453c, 17'h00145, 17'h1003c, 17'h10402, 17'h004fd, 17'h10401, 17'h10145,
    17'h12000, 17'h00302, 17'h00277, 17'h10200, 17'h10302, 17'h00aff, 17'h10a0f};
  always #50 clk_sys = ~clk_sys;
  dmsa_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .power_up(power_up),
    .wdt_halt_rst(wdt_halt_rst), .wdt_timeout(wdt_timeout), .watchdog_clear_instruction_exec(watchdog_clear_instruction_exec),
    .halt_exec(halt_exec), .core_rd(core_rd), .core_wr(core_wr), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata), .alu_upd(alu_upd),
    .alu_flags(alu_flags), .tbl_done(tbl_done), .tbl_word(tbl_word), .pc_page(pc_page),
    .tbl_addr(tbl_addr), .pcl_jump(pcl_jump), .dummy_cycle(dummy_cycle),
    .pcl_value(pcl_value), .halt_flag(halt_flag), .wdt_flag(wdt_flag),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dmsa_core_model cm (.clk_sys(clk_sys), .core_rd(core_rd), .core_wr(core_wr),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_rdata(core_rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic avx(input logic wr, input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    avx(1'b0, a, 8'h00);
    chk(r[7:0], e);
  endtask
  task automatic pulse(input logic [2:0] w);
    {wdt_timeout, watchdog_clear_instruction_exec, halt_exec} <= w;
    @(posedge clk_sys);
    {wdt_timeout, watchdog_clear_instruction_exec, halt_exec} <= 3'h0;
    @(posedge clk_sys);
  endtask
  task automatic do_reset(input logic pu, input logic wh);
    rst_n <= 1'b0;
    power_up <= pu;
    wdt_halt_rst <= wh;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    mismatches++;
    summarize;
  end
  initial begin
    do_reset(1'b1, 1'b0);
    foreach (rows[i]) begin
      if (rows[i][16]) begin
        cm.rd(rows[i][15:8], d8);
        chk(d8, rows[i][7:0]);
      end else begin
        cm.wr(rows[i][15:8], rows[i][7:0]);
      end
    end
    $display("core access table done");
    avx(1'b1, `DMSA_R_BANK, 8'hfe);
    rc(`DMSA_R_BANK, 8'h02);
    rc(4'hf, 8'h00);
    $display("register bus test done");
    pulse(3'h1);
    rc(`DMSA_R_STAT, 8'h1f);
    pulse(3'h4);
    rc(`DMSA_R_STAT, 8'h3f);
    avx(1'b1, `DMSA_R_STAT, 8'h00);
    rc(`DMSA_R_STAT, 8'h30);
    pulse(3'h1);
    rc(`DMSA_R_STAT, 8'h10);
    pulse(3'h4);
    do_reset(1'b0, 1'b1);
    rc(`DMSA_R_STAT, 8'h30);
    rc(`DMSA_R_BANK, 8'h02);
    pulse(3'h2);
    rc(`DMSA_R_STAT, 8'h00);
    do_reset(1'b0, 1'b0);
    rc(`DMSA_R_BANK, 8'h00);
    $display("flag and reset test done");
    alu_flags <= 4'ha;
    alu_upd <= 1'b1;
    @(posedge clk_sys);
    alu_upd <= 1'b0;
    @(posedge clk_sys);
    rc(`DMSA_R_STAT, 8'h0a);
    cm.wr(`DMSA_A_PCL, 8'h5a);
    chk(pcl_value, 8'h5a);
    cm.wr(`DMSA_A_TBLP, 8'h06);
    cm.wr(`DMSA_A_TABLE_ADDRESS_HIGH, 8'h0c);
    chk(tbl_addr[11:4], 8'h50);
    cm.wr(`DMSA_A_SYSTEM_CONTROL_REG, 8'h40);
    chk(tbl_addr[11:4], 8'hc0);
    tbl_word <= 16'h9a3c;
    tbl_done <= 1'b1;
    @(posedge clk_sys);
    tbl_done <= 1'b0;
    @(posedge clk_sys);
    rc(`DMSA_R_TABLE_HIGH_BYTE_OUT, 8'h9a);
    $display("table and jump test done");
    summarize;
  end
endmodule // tb_top

//--- verilog/dmsa_core.v
// Data-memory access, special registers, banking, table read and status flags
`include "dmsa_consts.vh"

module dmsa_core (
  input wire clk_sys, // System clock, 10 MHz
  input wire rst_n, // Synchronous reset, active low
  input wire power_up, // Reset came from power-up
  input wire wdt_halt_rst, // Reset is a watchdog time-out while asleep
  input wire wdt_timeout, // Watchdog time-out event pulse
  input wire watchdog_clear_instruction_exec, // Watchdog-clear instruction executed pulse
  input wire halt_exec, // Sleep instruction executed pulse
  input wire core_rd, // Core data-memory read strobe
  input wire core_wr, // Core data-memory write strobe
  input wire [7:0] core_addr, // Core data-memory address
  input wire [7:0] core_wdata, // Core write data
  output reg [7:0] core_rdata, // Core read data, registered
  input wire alu_upd, // Load arithmetic flags from operation result
  input wire [3:0] alu_flags, // Result flags: ov, z, ac, c
  input wire tbl_done, // Table read fetched a word
  input wire [15:0] tbl_word, // Fetched program word
  input wire [3:0] pc_page, // Current program counter bits 11..8
  output wire [11:0] tbl_addr, // Program address of a table read
  output reg pcl_jump, // Program-counter low byte written, pulse
  output reg dummy_cycle, // Inserted dummy cycle, pulse
  output wire [7:0] pcl_value, // Program counter low byte
  output wire halt_flag, // Sleep flag level
  output wire wdt_flag, // Watchdog flag level
  input wire [3:0] avs_address, // Avalon byte address
  input wire avs_read, // Avalon read
  input wire avs_write, // Avalon write
  input wire [31:0] avs_writedata, // Avalon write data
  input wire [3:0] avs_byteenable, // Avalon byte enables
  output reg [31:0] avs_readdata, // Avalon read data
  output wire avs_waitrequest // Avalon wait request
);

  // ****************************************
  // State
  // ****************************************
  reg [7:0] ptr0_reg;
  reg [7:0] ptr1_reg;
  reg [1:0] bank_reg;
  reg [7:0] work_reg;
  reg [7:0] pcl_reg;
  reg [7:0] tblp_reg;
  reg [7:0] table_high_byte_out_reg;
  reg [7:0] table_address_high_reg;
  reg [7:0] system_control_reg_reg;
  reg [5:0] stat_reg;
  reg [7:0] mem [0:767];
  reg av_ack_reg;

  // ****************************************
  // Address resolution
  // ****************************************
  reg [9:0] eff_addr;
  reg eff_null;
  reg is_ind;
  always @* begin
    eff_addr = {2'h0, core_addr};
    eff_null = 1'b0;
    is_ind = 1'b0;
    if (core_addr == `DMSA_A_IND0) begin
      is_ind = 1'b1;
      eff_addr = {2'h0, ptr0_reg};
    end else if (core_addr == `DMSA_A_IND1) begin
      is_ind = 1'b1;
      eff_addr = {bank_reg, ptr1_reg};
    end
    // Indirect target that is itself an indirect port
    if (is_ind && (eff_addr[7:0] == `DMSA_A_IND0 || eff_addr[7:0] == `DMSA_A_IND1))
      eff_null = 1'b1;
  end

  // Special registers decoded on the low byte only, in every bank
  wire [7:0] sa = eff_addr[7:0];
  wire is_gp = (sa >= `DMSA_GP_BASE);
  wire wr_ok = core_wr && !eff_null;
  // Each bank holds 192 general locations, packed back to back
  wire [9:0] bank_base = {1'b0, eff_addr[9:8], 7'h00} + {2'h0, eff_addr[9:8], 6'h00};
  wire [7:0] gp_off = sa - `DMSA_GP_BASE;
  wire [9:0] mem_idx = bank_base + {2'h0, gp_off};

  reg [7:0] sfr_rd;
  always @* begin
    case (sa)
      `DMSA_A_PTR0: sfr_rd = ptr0_reg;
      `DMSA_A_PTR1: sfr_rd = ptr1_reg;
      `DMSA_A_BANK: sfr_rd = {6'h00, bank_reg};
      `DMSA_A_WORK: sfr_rd = work_reg;
      `DMSA_A_PCL: sfr_rd = pcl_reg;
      `DMSA_A_TBLP: sfr_rd = tblp_reg;
      `DMSA_A_TABLE_HIGH_BYTE_OUT: sfr_rd = table_high_byte_out_reg;
      `DMSA_A_TABLE_ADDRESS_HIGH: sfr_rd = table_address_high_reg;
      `DMSA_A_STAT: sfr_rd = {2'h0, stat_reg};
      `DMSA_A_SYSTEM_CONTROL_REG: sfr_rd = system_control_reg_reg;
      default: sfr_rd = 8'h00;
    endcase
  end

  reg [7:0] core_rdata_next;
  always @* begin
    core_rdata_next = core_rdata;
    if (core_rd) begin
      if (eff_null)
        core_rdata_next = 8'h00;
      else if (is_gp)
        core_rdata_next = mem[mem_idx];
      else
        core_rdata_next = sfr_rd;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n)
      core_rdata <= 8'h00;
    else
      core_rdata <= core_rdata_next;
  end

  // General-purpose and display memory; only the core writes it, one location
  // per instruction, so moves between locations go via the working register
  always @(posedge clk_sys) begin
    if (wr_ok && is_gp)
      mem[mem_idx] <= core_wdata;
  end

  // ****************************************
  // Avalon slave
  // ****************************************
  wire av_req = avs_read || avs_write;
  wire av_take = av_req && av_ack_reg;
  assign avs_waitrequest = av_req && !av_ack_reg;
  wire av_wr = av_take && avs_write && avs_byteenable[0];
  wire [7:0] av_d = avs_writedata[7:0];
  // One write enable per bus register except the read-only table high byte output
  wire av_w_bank = av_wr && avs_address == `DMSA_R_BANK;
  wire av_w_stat = av_wr && avs_address == `DMSA_R_STAT;
  wire av_w_system_control_reg = av_wr && avs_address == `DMSA_R_SYSTEM_CONTROL_REG;
  wire av_w_table_address_high = av_wr && avs_address == `DMSA_R_TABLE_ADDRESS_HIGH;
  wire av_w_pcl = av_wr && avs_address == `DMSA_R_PCL;
  wire av_w_work = av_wr && avs_address == `DMSA_R_WORK;
  wire av_w_ptr0 = av_wr && avs_address == `DMSA_R_PTR0;
  wire av_w_ptr1 = av_wr && avs_address == `DMSA_R_PTR1;

  always @(posedge clk_sys) begin
    if (!rst_n)
      av_ack_reg <= 1'b0;
    else
      av_ack_reg <= av_req && !av_ack_reg;
  end

  reg [7:0] av_rd;
  always @* begin
    case (avs_address)
      `DMSA_R_BANK: av_rd = {6'h00, bank_reg};
      `DMSA_R_STAT: av_rd = {2'h0, stat_reg};
      `DMSA_R_SYSTEM_CONTROL_REG: av_rd = system_control_reg_reg;
      `DMSA_R_TABLE_ADDRESS_HIGH: av_rd = table_address_high_reg;
      `DMSA_R_TABLE_HIGH_BYTE_OUT: av_rd = table_high_byte_out_reg;
      `DMSA_R_PCL: av_rd = pcl_reg;
      `DMSA_R_WORK: av_rd = work_reg;
      `DMSA_R_PTR0: av_rd = ptr0_reg;
      `DMSA_R_PTR1: av_rd = ptr1_reg;
      default: av_rd = 8'h00;
    endcase
  end

  reg [31:0] av_rdata_next;
  always @* begin
    av_rdata_next = avs_readdata;
    if (avs_read && !av_ack_reg)
      av_rdata_next = {24'h000000, av_rd};
  end

  always @(posedge clk_sys) begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else
      avs_readdata <= av_rdata_next;
  end

  // Core write wins over a bus write to the same register in one cycle
  wire cw_ptr0 = wr_ok && sa == `DMSA_A_PTR0;
  wire cw_ptr1 = wr_ok && sa == `DMSA_A_PTR1;
  wire cw_bank = wr_ok && sa == `DMSA_A_BANK;
  wire cw_work = wr_ok && sa == `DMSA_A_WORK;
  wire cw_pcl = wr_ok && sa == `DMSA_A_PCL;
  wire cw_tblp = wr_ok && sa == `DMSA_A_TBLP;
  wire cw_table_address_high = wr_ok && sa == `DMSA_A_TABLE_ADDRESS_HIGH;
  wire cw_stat = wr_ok && sa == `DMSA_A_STAT;
  wire cw_system_control_reg = wr_ok && sa == `DMSA_A_SYSTEM_CONTROL_REG;

  // ****************************************
  // Pointers, bank, working and table registers
  // ****************************************
  reg [7:0] ptr0_next;
  reg [7:0] ptr1_next;
  reg [7:0] work_next;
  reg [7:0] tblp_next;
  reg [7:0] table_address_high_next;
  reg [7:0] system_control_reg_next;
  always @* begin
    ptr0_next = ptr0_reg;
    ptr1_next = ptr1_reg;
    work_next = work_reg;
    tblp_next = tblp_reg;
    table_address_high_next = table_address_high_reg;
    system_control_reg_next = system_control_reg_reg;
    if (cw_ptr0)
      ptr0_next = core_wdata;
    else if (av_w_ptr0)
      ptr0_next = av_d;
    if (cw_ptr1)
      ptr1_next = core_wdata;
    else if (av_w_ptr1)
      ptr1_next = av_d;
    if (cw_work)
      work_next = core_wdata;
    else if (av_w_work)
      work_next = av_d;
    if (cw_tblp)
      tblp_next = core_wdata;
    if (cw_table_address_high)
      table_address_high_next = core_wdata;
    else if (av_w_table_address_high)
      table_address_high_next = av_d;
    if (cw_system_control_reg)
      system_control_reg_next = core_wdata & `DMSA_SYSTEM_CONTROL_REG_MASK;
    else if (av_w_system_control_reg)
      system_control_reg_next = av_d & `DMSA_SYSTEM_CONTROL_REG_MASK;
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr0_reg <= 8'h00;
      ptr1_reg <= 8'h00;
      work_reg <= 8'h00;
      tblp_reg <= 8'h00;
      table_address_high_reg <= 8'h00;
      system_control_reg_reg <= `DMSA_SYSTEM_CONTROL_REG_RST;
    end else begin
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next;
      work_reg <= work_next;
      tblp_reg <= tblp_next;
      table_address_high_reg <= table_address_high_next;
      system_control_reg_reg <= system_control_reg_next;
    end
  end

  // Bank bits survive only the watchdog reset taken while asleep
  reg [1:0] bank_next;
  always @* begin
    bank_next = bank_reg;
    if (cw_bank)
      bank_next = core_wdata[1:0];
    else if (av_w_bank)
      bank_next = av_d[1:0];
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      if (!wdt_halt_rst)
        bank_reg <= `DMSA_BANK_RST;
    end else begin
      bank_reg <= bank_next;
    end
  end

  // Table address: page from table high register only when enabled
  wire tb_en = system_control_reg_reg[`DMSA_SC_TBEN];
  assign tbl_addr = {tb_en ? table_address_high_reg[3:0] : pc_page, tblp_reg};

  reg [7:0] table_high_byte_out_next;
  always @* begin
    table_high_byte_out_next = table_high_byte_out_reg;
    if (tbl_done)
      table_high_byte_out_next = tbl_word[15:8];
  end

  always @(posedge clk_sys) begin
    if (!rst_n)
      table_high_byte_out_reg <= 8'h00;
    else
      table_high_byte_out_reg <= table_high_byte_out_next;
  end

  // ****************************************
  // Program counter low byte
  // ****************************************
  reg [7:0] pcl_next;
  reg pcl_wr_any;
  always @* begin
    pcl_next = pcl_reg;
    pcl_wr_any = 1'b0;
    if (cw_pcl) begin
      pcl_next = core_wdata;
      pcl_wr_any = 1'b1;
    end else if (av_w_pcl) begin
      pcl_next = av_d;
      pcl_wr_any = 1'b1;
    end
  end

  // Jump pulse one cycle after the write, dummy cycle in the next
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pcl_reg <= 8'h00;
      pcl_jump <= 1'b0;
      dummy_cycle <= 1'b0;
    end else begin
      pcl_reg <= pcl_next;
      pcl_jump <= pcl_wr_any;
      dummy_cycle <= pcl_jump;
    end
  end
  assign pcl_value = pcl_reg;

  // ****************************************
  // Status register; not stacked on calls or interrupts
  // ****************************************
  wire [3:0] st_w = cw_stat ? core_wdata[3:0] : av_d[3:0];
  wire st_wr = cw_stat || av_w_stat;
  reg [5:0] stat_next;
  always @* begin
    stat_next = stat_reg;
    // Time-out wins over a same-cycle clear
    if (wdt_timeout)
      stat_next[`DMSA_ST_WDT] = 1'b1;
    else if (watchdog_clear_instruction_exec || halt_exec)
      stat_next[`DMSA_ST_WDT] = 1'b0;
    if (halt_exec)
      stat_next[`DMSA_ST_SLP] = 1'b1;
    else if (watchdog_clear_instruction_exec)
      stat_next[`DMSA_ST_SLP] = 1'b0;
    if (st_wr)
      stat_next[3:0] = st_w;
    else if (alu_upd)
      stat_next[3:0] = alu_flags;
  end

  // Of the resets, only a power-up reset clears the sleep and watchdog flags
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      if (power_up) begin
        stat_reg[`DMSA_ST_WDT] <= 1'b0;
        stat_reg[`DMSA_ST_SLP] <= 1'b0;
      end
      stat_reg[3:0] <= 4'h0;
    end else begin
      stat_reg <= stat_next;
    end
  end
  assign halt_flag = stat_reg[`DMSA_ST_SLP];
  assign wdt_flag = stat_reg[`DMSA_ST_WDT];

endmodule // dmsa_core
